// ===== core/alc_pkg.sv
package alc_pkg;

	// ==========================================================
	// Register map (byte addresses)
	// ==========================================================
	localparam logic [15:0] ALC_CTRL_SET_OFS = 16'hF700;
	localparam logic [15:0] ALC_CTRL_CLR_OFS = 16'hF704;
	localparam logic [15:0] ALC_HALT_STS_OFS = 16'hF708;
	localparam logic [15:0] ALC_INT_STS_OFS = 16'hF710;
	localparam logic [15:0] ALC_INT_MASK_OFS = 16'hF714;

	// ==========================================================
	// Control register fields
	// ==========================================================
	localparam int ALC_AUDIO_RX_EHALT_BIT = 20;
	localparam int ALC_SURR_TX_EHALT_BIT = 17;
	localparam int ALC_PCM_TX_EHALT_BIT = 16;
	localparam int ALC_MODEM_RX_DMA_BIT = 15;
	localparam int ALC_MODEM_TX_DMA_BIT = 14;
	localparam int ALC_AUDIO_RX_DMA_BIT = 12;
	localparam int ALC_LOWFREQ_TX_DMA_BIT = 11;
	localparam int ALC_CENTER_TX_DMA_BIT = 10;
	localparam int ALC_SURR_TX_DMA_BIT = 9;
	localparam int ALC_PCM_TX_DMA_BIT = 8;
	localparam int ALC_CODEC_RDY_CLR_BIT = 5;
	localparam int ALC_RX_SRC_SEL_BIT = 4;
	// Bits that hold state; everything else reads zero
	localparam logic [31:0] ALC_CTRL_MASK = 32'h0013DF10;
	localparam logic [31:0] ALC_CTRL_RESET = 32'h00000000;

	// ==========================================================
	// Channel numbering and side registers
	// ==========================================================
	localparam int ALC_NCH = 7;
	localparam int ALC_CH_PCM_TX = 0;
	localparam int ALC_CH_SURR_TX = 1;
	localparam int ALC_CH_AUDIO_RX = 4;
	localparam logic [6:0] ALC_CH_RESET = 7'h00;
	localparam logic [2:0] ALC_INT_RESET = 3'h0;

	// Per-channel inputs from the FIFO side
	typedef struct packed
	{
		logic [6:0] req;
		logic [6:0] err;
	} alc_chan_in_t;

endpackage

// ===== core/alc_ctrl_set.sv
`timescale 1ns/1ns

// Behaviour
// - Surround tx underrun with its halt enable set stops surround DMA requests.
// - PCM tx underrun with its halt enable set stops PCM DMA requests.
// - Bit 15 modem rx DMA enable: write one sets, zero ignored, readable.
// - Bit 14 modem tx DMA enable: set-only, readable.
// - Bit 12 audio rx DMA enable: set-only, readable.
// - Bit 11 low-frequency tx DMA enable: set-only, readable.
// - Bit 10 center tx DMA enable: set-only, readable.
// - Bit 9 surround tx DMA enable: set-only, readable.
// - Bit 8 PCM tx DMA enable: set-only, readable.
// - Bit 5 write-only; writing one clears both codec ready flags.
// - Bit 4 picks rx source: zero PCM slots 3 and 4, one mic slot 6.
// - Audio rx overrun with its halt enable set stops audio rx requests.
// - All fields reset to zero.
// - Companion clear register disables each field individually.
module alc_ctrl_set #(
	parameter int ADDR_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire alc_pkg::alc_chan_in_t chan_in,
	output logic [6:0] dma_req,
	output logic codec_ready_clear,
	output logic rx_source_select,
	output logic irq
);

	// ==========================================================
	// Elaboration checks
	// ==========================================================
	if (ADDR_W < 16 || ADDR_W > 32)
	begin : g_bad_addr_w
		$error("ADDR_W must lie between 16 and 32");
	end

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed
	{
		logic [31:0] ctrl;
		logic [6:0] halted;
		logic [2:0] int_sts;
		logic [2:0] int_mask;
		logic [6:0] dma_req;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic rdy_clr;
		logic irq;
	} alc_state_t;

	alc_state_t st_r;
	alc_state_t st_nxt;

	// Channel enables in channel order
	function automatic logic [6:0] chan_en(input logic [31:0] c);
		chan_en = {c[alc_pkg::ALC_MODEM_RX_DMA_BIT],
			c[alc_pkg::ALC_MODEM_TX_DMA_BIT],
			c[alc_pkg::ALC_AUDIO_RX_DMA_BIT:alc_pkg::ALC_PCM_TX_DMA_BIT]};
	endfunction

	// Error-halt enables in channel order; only three channels have one
	function automatic logic [6:0] halt_en(input logic [31:0] c);
		halt_en = 7'h00;
		halt_en[alc_pkg::ALC_CH_PCM_TX] = c[alc_pkg::ALC_PCM_TX_EHALT_BIT];
		halt_en[alc_pkg::ALC_CH_SURR_TX] = c[alc_pkg::ALC_SURR_TX_EHALT_BIT];
		halt_en[alc_pkg::ALC_CH_AUDIO_RX] =
			c[alc_pkg::ALC_AUDIO_RX_EHALT_BIT];
	endfunction

	// Address match on the low 16 bits, upper bits must be zero
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [15:0] ofs);
		hit = (a == ADDR_W'(ofs));
	endfunction

	logic acc_done;
	logic wr_done;
	logic clr_wr;
	logic mapped;
	logic [6:0] en_nxt;
	logic [6:0] halt_ev;
	logic [31:0] wmask;

	// Access completes at the edge where pready is seen high
	assign acc_done = psel && penable && st_r.pready;
	assign wr_done = acc_done && pwrite;
	assign clr_wr = wr_done && hit(paddr, alc_pkg::ALC_CTRL_CLR_OFS);
	assign wmask = pwdata & alc_pkg::ALC_CTRL_MASK;
	assign mapped = hit(paddr, alc_pkg::ALC_CTRL_SET_OFS) ||
		hit(paddr, alc_pkg::ALC_CTRL_CLR_OFS) ||
		hit(paddr, alc_pkg::ALC_HALT_STS_OFS) ||
		hit(paddr, alc_pkg::ALC_INT_STS_OFS) ||
		hit(paddr, alc_pkg::ALC_INT_MASK_OFS);

	// ==========================================================
	// Next-state logic
	// ==========================================================
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rdy_clr = 1'b0;
		// Set-only writes; zero bits leave fields alone
		if (wr_done && hit(paddr, alc_pkg::ALC_CTRL_SET_OFS))
		begin
			// Enables only ever gain bits here
			st_nxt.ctrl = st_r.ctrl | wmask;
			// Write-only pulse, never stored
			st_nxt.rdy_clr = pwdata[alc_pkg::ALC_CODEC_RDY_CLR_BIT];
		end
		// Companion clear register
		if (wr_done && hit(paddr, alc_pkg::ALC_CTRL_CLR_OFS))
		begin
			st_nxt.ctrl = st_r.ctrl & ~wmask;
		end
		if (wr_done && hit(paddr, alc_pkg::ALC_INT_MASK_OFS))
		begin
			st_nxt.int_mask = pwdata[2:0];
		end
		en_nxt = chan_en(st_nxt.ctrl);
		// A halt needs the channel running and the error this cycle
		halt_ev = chan_en(st_r.ctrl) & halt_en(st_r.ctrl) & chan_in.err &
			~st_r.halted;
		// Halt sticks until the enable drops
		st_nxt.halted = en_nxt & (st_r.halted | halt_ev);
		st_nxt.dma_req = chan_in.req & en_nxt & ~st_nxt.halted;
		// Sticky events, W1C; a new event beats a same-cycle clear
		if (wr_done && hit(paddr, alc_pkg::ALC_INT_STS_OFS))
		begin
			st_nxt.int_sts = st_r.int_sts & ~pwdata[2:0];
		end
		st_nxt.int_sts = st_nxt.int_sts |
			{halt_ev[alc_pkg::ALC_CH_AUDIO_RX],
			halt_ev[alc_pkg::ALC_CH_SURR_TX],
			halt_ev[alc_pkg::ALC_CH_PCM_TX]};
		st_nxt.irq = |(st_nxt.int_sts & st_nxt.int_mask);
		// One wait state: pready rises the cycle after the first access-phase cycle
		st_nxt.pready = psel && penable && !st_r.pready;
		st_nxt.pslverr = psel && penable && !st_r.pready && !mapped;
		st_nxt.prdata = 32'h00000000;
		if (psel && penable && !st_r.pready && !pwrite)
		begin
			if (hit(paddr, alc_pkg::ALC_CTRL_SET_OFS))
			begin
				st_nxt.prdata = st_r.ctrl;
			end
			else if (hit(paddr, alc_pkg::ALC_HALT_STS_OFS))
			begin
				st_nxt.prdata = {25'h0000000, st_r.halted};
			end
			else if (hit(paddr, alc_pkg::ALC_INT_STS_OFS))
			begin
				st_nxt.prdata = {29'h00000000, st_r.int_sts};
			end
			else if (hit(paddr, alc_pkg::ALC_INT_MASK_OFS))
			begin
				st_nxt.prdata = {29'h00000000, st_r.int_mask};
			end
			else
			begin
				st_nxt.prdata = 32'h00000000;
			end
		end
	end

	// ==========================================================
	// State register
	// ==========================================================
	// Everything resets to zero, all DMA and halts off
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r.ctrl <= alc_pkg::ALC_CTRL_RESET;
			st_r.halted <= alc_pkg::ALC_CH_RESET;
			st_r.int_sts <= alc_pkg::ALC_INT_RESET;
			st_r.int_mask <= alc_pkg::ALC_INT_RESET;
			st_r.dma_req <= alc_pkg::ALC_CH_RESET;
			st_r.pready <= 1'b0;
			st_r.pslverr <= 1'b0;
			st_r.prdata <= 32'h00000000;
			st_r.rdy_clr <= 1'b0;
			st_r.irq <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign prdata = st_r.prdata;
	assign dma_req = st_r.dma_req;
	assign codec_ready_clear = st_r.rdy_clr;
	assign rx_source_select = st_r.ctrl[alc_pkg::ALC_RX_SRC_SEL_BIT];
	assign irq = st_r.irq;

	// ==========================================================
	// Assertions
	// ==========================================================
	sequence s_set_wr;
		wr_done && hit(paddr, alc_pkg::ALC_CTRL_SET_OFS);
	endsequence

	sequence s_clr_wr;
		wr_done && hit(paddr, alc_pkg::ALC_CTRL_CLR_OFS);
	endsequence

	property p_surr_halt;
		@(posedge pclk) disable iff (!presetn)
		(st_r.ctrl[alc_pkg::ALC_SURR_TX_EHALT_BIT] &&
		st_r.ctrl[alc_pkg::ALC_SURR_TX_DMA_BIT] && chan_in.err[1])
		|=> !dma_req[1] && st_r.halted[1];
	endproperty
	a_surr_halt: assert property (p_surr_halt)
		else $error("surround requests continue after underrun halt");

	property p_pcm_halt;
		@(posedge pclk) disable iff (!presetn)
		(st_r.ctrl[alc_pkg::ALC_PCM_TX_EHALT_BIT] &&
		st_r.ctrl[alc_pkg::ALC_PCM_TX_DMA_BIT] && chan_in.err[0])
		|=> !dma_req[0] && st_r.halted[0];
	endproperty
	a_pcm_halt: assert property (p_pcm_halt)
		else $error("pcm requests continue after underrun halt");

	property p_arx_halt;
		@(posedge pclk) disable iff (!presetn)
		(st_r.ctrl[alc_pkg::ALC_AUDIO_RX_EHALT_BIT] &&
		st_r.ctrl[alc_pkg::ALC_AUDIO_RX_DMA_BIT] && chan_in.err[4] &&
		!st_r.halted[4])
		|=> !dma_req[4] && st_r.int_sts[2];
	endproperty
	a_arx_halt: assert property (p_arx_halt)
		else $error("audio rx halt or its interrupt missing");

	property p_set_only;
		@(posedge pclk) disable iff (!presetn)
		s_set_wr |=> (st_r.ctrl & $past(st_r.ctrl)) == $past(st_r.ctrl);
	endproperty
	a_set_only: assert property (p_set_only)
		else $error("write to set register cleared a field");

	property p_set_take;
		@(posedge pclk) disable iff (!presetn)
		s_set_wr ##0 (pwdata[15:8] == 8'hDF) |=>
		(chan_en(st_r.ctrl) == 7'h7F) ##1
		(psel && penable && !pwrite &&
		hit(paddr, alc_pkg::ALC_CTRL_SET_OFS))[*2] |->
		prdata[15:8] == 8'hDF;
	endproperty
	a_set_take: assert property (p_set_take)
		else $error("enable set by write not visible");

	property p_clr;
		@(posedge pclk) disable iff (!presetn)
		s_clr_wr |=> (st_r.ctrl & $past(wmask)) == 32'h00000000;
	endproperty
	a_clr: assert property (p_clr)
		else $error("companion register failed to clear field");

	property p_rdy_pulse;
		@(posedge pclk) disable iff (!presetn)
		s_set_wr ##0 pwdata[alc_pkg::ALC_CODEC_RDY_CLR_BIT] |=>
		codec_ready_clear ##1 !codec_ready_clear;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse)
		else $error("codec ready clear not a one-cycle pulse");

	property p_reserved;
		@(posedge pclk) disable iff (!presetn)
		st_r.pready && !pwrite && hit(paddr, alc_pkg::ALC_CTRL_SET_OFS)
		|-> prdata[13] == 1'b0 && prdata[7:5] == 3'h0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved control bits read nonzero");

	property p_sticky;
		@(posedge pclk) disable iff (!presetn)
		st_r.halted[1] && !clr_wr
		|=> st_r.halted[1] && !dma_req[1];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("halted surround channel resumed without re-enable");

	property p_reset;
		@(posedge pclk)
		!presetn |-> st_r.ctrl == 32'h00000000 && dma_req == 7'h00;
	endproperty
	a_reset: assert property (p_reset)
		else $error("control fields not zero under reset");

	property p_src;
		@(posedge pclk) disable iff (!presetn)
		rx_source_select |=> rx_source_select || $past(clr_wr);
	endproperty
	a_src: assert property (p_src)
		else $error("rx source select dropped without a clear");

endmodule // alc_ctrl_set

// ===== tb/alc_fifo_model.sv
`timescale 1ns/1ns

// ==========================================================
// FIFO side model: request levels and error pulses
// ==========================================================
module alc_fifo_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [6:0] err_cmd,
	output alc_pkg::alc_chan_in_t chan_in
);
	// Requests wander every cycle, so DMA gating is seen under load
	// Transfers are assumed sized to the whole tx FIFO depth
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			chan_in <= 14'h0000;
		else
		begin
			chan_in.req <= 7'($urandom);
			chan_in.err <= err_cmd; // Faults only when the bench asks
		end
	end
endmodule // alc_fifo_model

// ===== tb/alc_ctrl_set_tb_top.sv
`timescale 1ns/1ns

// ==========================================================
// Bench for the control set register
// ==========================================================
module alc_ctrl_set_tb_top;
	localparam logic [15:0] SET = alc_pkg::ALC_CTRL_SET_OFS;
	localparam logic [15:0] CLR = alc_pkg::ALC_CTRL_CLR_OFS;
	localparam logic [31:0] MSK = alc_pkg::ALC_CTRL_MASK;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, chk;
	logic codec_ready_clear, rx_source_select, irq;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, ctrl, d;
	logic [6:0] dma_req, err_cmd, en, hen, halt, nh, exp_d;
	alc_pkg::alc_chan_in_t chan_in;
	logic [32:0] q[$];
	int err_count, comparisons, cyc, pulses, exp_pulses;

	alc_ctrl_set i_alc_ctrl_set (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .chan_in,
		.dma_req, .codec_ready_clear, .rx_source_select, .irq);
	alc_fifo_model i_alc_fifo_model (.pclk, .presetn, .err_cmd, .chan_in);

	// Expected channel state, derived from the bench's copy of ctrl
	assign en = {ctrl[15:14], ctrl[12:8]};
	assign hen = {2'h0, ctrl[20], 2'h0, ctrl[17:16]};
	assign nh = (halt & en) | (chan_in.err & en & hen);

	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task cmp(input logic [32:0] g, input logic [32:0] e);
		comparisons++;
		if (g !== e)
		begin
			err_count++;
			$display("FAIL %0t got %h expected %h", $time, g, e);
		end
	endtask

	task complete_run;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// One APB transfer; reads note their expected answer in the queue
	task apb(input logic w, input logic [15:0] a, input logic [31:0] v,
		input logic [32:0] e);
		@(posedge pclk);
		chk <= 1'b0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		if (!w)
			q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		if (w && a == SET)
			exp_pulses += v[5];
		if (w && a == SET)
			ctrl = ctrl | (v & MSK);
		if (w && a == CLR)
			ctrl = ctrl & ~(v & MSK);
		// Settle two cycles so request checks never straddle a commit
		repeat (2) @(posedge pclk);
		chk <= 1'b1;
	endtask

	task err_pulse(input logic [6:0] m);
		@(posedge pclk);
		err_cmd <= m;
		@(posedge pclk);
		err_cmd <= 7'h00;
		repeat (3) @(posedge pclk);
	endtask

	// Output watcher: oldest note against each answer, requests each edge while chk is set
	always @(posedge pclk)
	begin
		if (pready === 1'b1 && pwrite === 1'b0)
			cmp({pslverr, prdata}, q.pop_front());
		if (chk)
			cmp(dma_req, exp_d);
		if (codec_ready_clear === 1'b1)
			pulses++;
		exp_d <= chan_in.req & en & ~nh;
		halt <= presetn ? nh : 7'h00;
	end

	// Hang guard
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_count++;
			complete_run;
		end
	end

	initial
	begin
		void'($urandom(5030));
		{presetn, psel, penable, pwrite, chk} = 5'h00;
		{paddr, pwdata, ctrl, err_cmd} = 87'h0;
		repeat (5) @(posedge pclk);
		@(negedge pclk);
		cmp({dma_req, codec_ready_clear, rx_source_select, irq}, 0);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(0, SET, 0, 0);
		apb(1, SET, 32'hFFFFFFFF, 0);
		apb(0, SET, 0, {1'b0, MSK});
		cmp(rx_source_select, 1);
		repeat (20) @(posedge pclk);
		apb(1, CLR, 32'hFFFFFFFF, 0);
		apb(0, SET, 0, 0);
		cmp(rx_source_select, 0);
		// Random sets and clears, each read back
		repeat (6)
		begin
			d = $urandom;
			apb(1, SET, d, 0);
			apb(0, SET, 0, {1'b0, ctrl});
			d = $urandom;
			apb(1, CLR, d, 0);
			apb(0, SET, 0, {1'b0, ctrl});
		end
		apb(0, 16'hF7F0, 0, {1'b1, 32'h00000000});
		// Error halts on pcm, surround and audio rx; center has no halt
		apb(1, CLR, 32'hFFFFFFFF, 0);
		apb(1, alc_pkg::ALC_INT_MASK_OFS, 32'h00000007, 0);
		apb(1, SET, 32'h0013DF00, 0);
		err_pulse(7'h01);
		@(negedge pclk);
		cmp(irq, 1);
		apb(0, alc_pkg::ALC_HALT_STS_OFS, 0, 33'h000000001);
		err_pulse(7'h02);
		err_pulse(7'h14);
		apb(0, alc_pkg::ALC_HALT_STS_OFS, 0, 33'h000000013);
		apb(0, alc_pkg::ALC_INT_STS_OFS, 0, 33'h000000007);
		apb(1, alc_pkg::ALC_INT_STS_OFS, 32'h00000007, 0);
		@(negedge pclk);
		cmp(irq, 0);
		apb(1, SET, 32'h00001300, 0);
		repeat (10) @(posedge pclk);
		apb(1, CLR, 32'h00001300, 0);
		apb(1, SET, 32'h00001300, 0);
		repeat (10) @(posedge pclk);
		apb(1, SET, 32'h00000020, 0); // After a codec power-down
		@(negedge pclk);
		cmp(pulses, exp_pulses);
		complete_run;
	end
endmodule // alc_ctrl_set_tb_top
